// [liu_pkg.sv]
// Constants, field layouts and shared types for the line interface
// register bank. Assumes one 100 MHz clock and a host front end that
// delivers one decoded access per strobe.
package liu_pkg;

  //////////////////////////////////////////////////////////////////////
  // Widths
  localparam int LIU_ADDR_W = 5;
  localparam int LIU_DATA_W = 8;
  localparam int LIU_TPL_DEPTH = 8;
  localparam int LIU_TPL_IDX_W = 3;

  //////////////////////////////////////////////////////////////////////
  // Primary bank offsets
  localparam logic [4:0] OFS_DEVICE_CODE = 5'h00;
  localparam logic [4:0] OFS_ANALOG_LB = 5'h01;
  localparam logic [4:0] OFS_REMOTE_LB = 5'h02;
  localparam logic [4:0] OFS_ALL_ONES = 5'h03;
  localparam logic [4:0] OFS_SA_STATUS = 5'h04;
  localparam logic [4:0] OFS_DF_STATUS = 5'h05;
  localparam logic [4:0] OFS_SA_MASK = 5'h06;
  localparam logic [4:0] OFS_DF_MASK = 5'h07;
  localparam logic [4:0] OFS_SA_FLAG = 5'h08;
  localparam logic [4:0] OFS_DF_FLAG = 5'h09;
  localparam logic [4:0] OFS_SOFT_RESET = 5'h0a;
  localparam logic [4:0] OFS_MONITOR_SEL = 5'h0b;
  localparam logic [4:0] OFS_DIGITAL_LB = 5'h0c;
  localparam logic [4:0] OFS_DETECT_CRIT = 5'h0d;
  localparam logic [4:0] OFS_AUTO_ONES = 5'h0e;
  localparam logic [4:0] OFS_GLOBAL = 5'h0f;
  localparam logic [4:0] OFS_TPL_INDEX = 5'h10;
  localparam logic [4:0] OFS_TPL_DATA = 5'h11;
  localparam logic [4:0] OFS_OUT_EN = 5'h12;
  localparam logic [4:0] OFS_AS_STATUS = 5'h13;
  localparam logic [4:0] OFS_AS_MASK = 5'h14;
  localparam logic [4:0] OFS_AS_FLAG = 5'h15;
  localparam logic [4:0] OFS_RSVD_FIRST = 5'h16;
  localparam logic [4:0] OFS_RSVD_LAST = 5'h1e;
  localparam logic [4:0] OFS_BANK_PTR = 5'h1f;

  //////////////////////////////////////////////////////////////////////
  // Values and reset values
  localparam logic [7:0] BANK_EXPANDED = 8'haa;
  localparam logic [7:0] BANK_PTR_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] TPL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } liu_host_req_t;

  typedef struct packed {
    logic [7:0] signal_absent;
    logic [7:0] driver_fault;
    logic [7:0] alarm_signal;
  } liu_line_stat_t;

  typedef struct packed {
    logic [7:0] analog_lb;
    logic [7:0] remote_lb;
    logic [7:0] all_ones;
    logic [7:0] monitor_sel;
    logic [7:0] digital_lb;
    logic [7:0] detect_crit;
    logic [7:0] auto_ones;
    logic [7:0] global_cfg;
    logic [7:0] out_en;
  } liu_line_cfg_t;

  // Sticky flag update: a status edge under mask sets, a status read
  // clears, and a set in the clearing cycle wins
  function automatic logic [7:0] liu_flag_next(input logic [7:0] flag,
                                               input logic [7:0] set,
                                               input logic clr);
    liu_flag_next = (clr ? FLAG_RESET : flag) | set;
  endfunction

endpackage

// [liu_template_table.sv]
// Transmit template table reached through the index/data pair.
// Assumes the caller qualifies writes and resets with the bank decode.
`timescale 1ns/1ps
module liu_template_table
  import liu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [LIU_TPL_IDX_W-1:0] idx_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [LIU_TPL_DEPTH*8-1:0] entries_o
);

  logic [7:0] tpl_ff [LIU_TPL_DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // Entry storage, cleared by hard or soft reset
  always_ff @(posedge ref_clk_i) begin
    if (clear_i) begin
      for (int i = 0; i < LIU_TPL_DEPTH; i++) begin
        tpl_ff[i] <= TPL_RESET;
      end
    end else if (wr_i) begin
      tpl_ff[idx_i] <= wdata_i;
    end
  end

  // Selected entry for the data register read
  assign rdata_o = tpl_ff[idx_i];

  // Flattened view for the line side
  always_comb begin
    entries_o = '0;
    for (int i = 0; i < LIU_TPL_DEPTH; i++) begin
      entries_o[i*8 +: 8] = tpl_ff[i];
    end
  end

endmodule

// [liu_register_bank.sv]
// Primary/expanded register bank decoder for the octal line interface.
// Assumes a host front end (parallel or serial) on the same clock that
// presents one access per acc_i pulse with a five-bit address.
`timescale 1ns/1ps
module liu_register_bank
  import liu_pkg::*;
#(
  parameter logic [7:0] DEVICE_CODE = 8'h5a // Arbitrary value
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic acc_i,
  input wire liu_host_req_t req_i,
  output logic rd_valid_o,
  output logic [7:0] rdata_o,
  output logic exp_acc_o,
  input wire logic [7:0] exp_rdata_i,
  input wire liu_line_stat_t line_stat_i,
  output liu_line_cfg_t line_cfg_o,
  output logic [LIU_TPL_DEPTH*8-1:0] tpl_entries_o,
  output logic soft_reset_o,
  output logic bank_expanded_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] bank_ptr_ff;
  logic expanded;
  logic pri_acc;
  logic pri_wr;
  logic pri_rd;
  logic soft_hit;
  logic clear_all;
  liu_line_cfg_t cfg_ff;
  logic [7:0] sa_mask_ff;
  logic [7:0] df_mask_ff;
  logic [7:0] as_mask_ff;
  logic [7:0] sa_flag_ff;
  logic [7:0] df_flag_ff;
  logic [7:0] as_flag_ff;
  liu_line_stat_t stat_prev_ff;
  logic [7:0] sa_set;
  logic [7:0] df_set;
  logic [7:0] as_set;
  logic [7:0] tpl_index_ff;
  logic [7:0] tpl_rdata;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic rd_valid_ff;
  logic soft_reset_ff;

  ////////////////////////////////////////////////////////////////////////
  // Bank decode; the pointer itself stays reachable from either bank
  assign expanded = (bank_ptr_ff == BANK_EXPANDED);
  assign exp_acc_o = acc_i && expanded && (req_i.addr != OFS_BANK_PTR);
  assign pri_acc = acc_i && !exp_acc_o;
  assign pri_wr = pri_acc && req_i.wr;
  assign pri_rd = pri_acc && !req_i.wr;
  assign soft_hit = pri_wr && (req_i.addr == OFS_SOFT_RESET);
  assign clear_all = srst_i || soft_hit;
  assign bank_expanded_o = expanded;

  // Bank pointer register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bank_ptr_ff <= BANK_PTR_RESET;
    end else if (acc_i && req_i.wr && req_i.addr == OFS_BANK_PTR) begin
      bank_ptr_ff <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line configuration registers; reserved and read-only offsets fall
  // through the case untouched
  always_ff @(posedge ref_clk_i) begin
    if (clear_all) begin
      cfg_ff <= '{default: CFG_RESET};
    end else if (pri_wr) begin
      case (req_i.addr)
        OFS_ANALOG_LB: cfg_ff.analog_lb <= req_i.wdata;
        OFS_REMOTE_LB: cfg_ff.remote_lb <= req_i.wdata;
        OFS_ALL_ONES: cfg_ff.all_ones <= req_i.wdata;
        OFS_MONITOR_SEL: cfg_ff.monitor_sel <= req_i.wdata;
        OFS_DIGITAL_LB: cfg_ff.digital_lb <= req_i.wdata;
        OFS_DETECT_CRIT: cfg_ff.detect_crit <= req_i.wdata;
        OFS_AUTO_ONES: cfg_ff.auto_ones <= req_i.wdata;
        OFS_GLOBAL: cfg_ff.global_cfg <= req_i.wdata;
        OFS_OUT_EN: cfg_ff.out_en <= req_i.wdata;
        default: ;
      endcase
    end
  end

  assign line_cfg_o = cfg_ff;

  // Interrupt mask registers
  always_ff @(posedge ref_clk_i) begin
    if (clear_all) begin
      sa_mask_ff <= MASK_RESET;
      df_mask_ff <= MASK_RESET;
      as_mask_ff <= MASK_RESET;
    end else if (pri_wr) begin
      if (req_i.addr == OFS_SA_MASK) sa_mask_ff <= req_i.wdata;
      if (req_i.addr == OFS_DF_MASK) df_mask_ff <= req_i.wdata;
      if (req_i.addr == OFS_AS_MASK) as_mask_ff <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status edge detection; each transition under mask raises a flag
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stat_prev_ff <= '0;
    end else begin
      stat_prev_ff <= line_stat_i;
    end
  end

  assign sa_set = sa_mask_ff &
                  (line_stat_i.signal_absent ^ stat_prev_ff.signal_absent);
  assign df_set = df_mask_ff &
                  (line_stat_i.driver_fault ^ stat_prev_ff.driver_fault);
  assign as_set = as_mask_ff &
                  (line_stat_i.alarm_signal ^ stat_prev_ff.alarm_signal);

  // Sticky flags, cleared by reading the matching status register
  always_ff @(posedge ref_clk_i) begin
    if (clear_all) begin
      sa_flag_ff <= FLAG_RESET;
      df_flag_ff <= FLAG_RESET;
      as_flag_ff <= FLAG_RESET;
    end else begin
      sa_flag_ff <= liu_flag_next(sa_flag_ff, sa_set,
                      pri_rd && req_i.addr == OFS_SA_STATUS);
      df_flag_ff <= liu_flag_next(df_flag_ff, df_set,
                      pri_rd && req_i.addr == OFS_DF_STATUS);
      as_flag_ff <= liu_flag_next(as_flag_ff, as_set,
                      pri_rd && req_i.addr == OFS_AS_STATUS);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Template index and table
  always_ff @(posedge ref_clk_i) begin
    if (clear_all) begin
      tpl_index_ff <= TPL_RESET;
    end else if (pri_wr && req_i.addr == OFS_TPL_INDEX) begin
      tpl_index_ff <= req_i.wdata;
    end
  end

  liu_template_table u_tpl (
    .ref_clk_i(ref_clk_i),
    .clear_i(clear_all),
    .wr_i(pri_wr && req_i.addr == OFS_TPL_DATA),
    .idx_i(tpl_index_ff[LIU_TPL_IDX_W-1:0]),
    .wdata_i(req_i.wdata),
    .rdata_o(tpl_rdata),
    .entries_o(tpl_entries_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    nxt_rdata = READ_ZERO;
    if (exp_acc_o) begin
      nxt_rdata = exp_rdata_i;
    end else begin
      unique case (req_i.addr)
        OFS_DEVICE_CODE: nxt_rdata = DEVICE_CODE;
        OFS_ANALOG_LB: nxt_rdata = cfg_ff.analog_lb;
        OFS_REMOTE_LB: nxt_rdata = cfg_ff.remote_lb;
        OFS_ALL_ONES: nxt_rdata = cfg_ff.all_ones;
        OFS_SA_STATUS: nxt_rdata = line_stat_i.signal_absent;
        OFS_DF_STATUS: nxt_rdata = line_stat_i.driver_fault;
        OFS_SA_MASK: nxt_rdata = sa_mask_ff;
        OFS_DF_MASK: nxt_rdata = df_mask_ff;
        OFS_SA_FLAG: nxt_rdata = sa_flag_ff;
        OFS_DF_FLAG: nxt_rdata = df_flag_ff;
        OFS_SOFT_RESET: nxt_rdata = READ_ZERO; // Write-only
        OFS_MONITOR_SEL: nxt_rdata = cfg_ff.monitor_sel;
        OFS_DIGITAL_LB: nxt_rdata = cfg_ff.digital_lb;
        OFS_DETECT_CRIT: nxt_rdata = cfg_ff.detect_crit;
        OFS_AUTO_ONES: nxt_rdata = cfg_ff.auto_ones;
        OFS_GLOBAL: nxt_rdata = cfg_ff.global_cfg;
        OFS_TPL_INDEX: nxt_rdata = tpl_index_ff;
        OFS_TPL_DATA: nxt_rdata = tpl_rdata;
        OFS_OUT_EN: nxt_rdata = cfg_ff.out_en;
        OFS_AS_STATUS: nxt_rdata = line_stat_i.alarm_signal;
        OFS_AS_MASK: nxt_rdata = as_mask_ff;
        OFS_AS_FLAG: nxt_rdata = as_flag_ff;
        OFS_BANK_PTR: nxt_rdata = bank_ptr_ff;
        default: nxt_rdata = READ_ZERO;
      endcase
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_valid_ff <= 1'b0;
      rdata_ff <= READ_ZERO;
    end else begin
      rd_valid_ff <= acc_i && !req_i.wr;
      if (acc_i && !req_i.wr) rdata_ff <= nxt_rdata;
    end
  end

  assign rd_valid_o = rd_valid_ff;
  assign rdata_o = rdata_ff;

  // Soft reset pulse toward the line logic
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= soft_hit;
    end
  end

  assign soft_reset_o = soft_reset_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_PTR_WRITE: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    acc_i && req_i.wr && req_i.addr == OFS_BANK_PTR
    |=> bank_ptr_ff == $past(req_i.wdata))
    else $error("bank pointer did not take written value");

  AST_BANK_EXP: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    acc_i && bank_ptr_ff == BANK_EXPANDED && req_i.addr != OFS_BANK_PTR
    |-> exp_acc_o ##1 (rd_valid_o == !$past(req_i.wr)))
    else $error("expanded access not routed");

  AST_BANK_PRI: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    bank_ptr_ff == BANK_PTR_RESET |-> !exp_acc_o)
    else $error("primary bank access leaked to expanded bank");

  AST_RSVD_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_rd && req_i.addr >= OFS_RSVD_FIRST && req_i.addr <= OFS_RSVD_LAST
    |=> rd_valid_o && rdata_o == READ_ZERO)
    else $error("reserved offset read not zero");

  AST_RSVD_WR: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_wr && req_i.addr >= OFS_RSVD_FIRST && req_i.addr <= OFS_RSVD_LAST
    |=> $stable(cfg_ff) && $stable(tpl_index_ff))
    else $error("reserved offset write changed state");

  AST_STATUS_RD: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_rd && req_i.addr == OFS_DF_STATUS
    |=> rdata_o == $past(line_stat_i.driver_fault))
    else $error("status read does not show line state");

  AST_MASK_RW: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_wr && req_i.addr == OFS_AS_MASK
    ##1 pri_rd && req_i.addr == OFS_AS_MASK
    |=> rdata_o == $past(req_i.wdata, 2))
    else $error("mask register read back mismatch");

  AST_FLAG_SET: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    sa_set != 8'h00 && !soft_hit
    |=> (sa_flag_ff & $past(sa_set)) == $past(sa_set))
    else $error("masked status change did not raise flag");

  AST_FLAG_CLR: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_rd && req_i.addr == OFS_SA_STATUS && sa_set == 8'h00
    |=> sa_flag_ff == FLAG_RESET)
    else $error("status read did not clear flag");

  AST_TPL_RW: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_wr && req_i.addr == OFS_TPL_DATA
    ##1 pri_rd && req_i.addr == OFS_TPL_DATA
    |=> rdata_o == $past(req_i.wdata, 2))
    else $error("template entry read back mismatch");

  AST_EXP_WR: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    exp_acc_o && req_i.wr
    |=> $stable(cfg_ff) && $stable(tpl_index_ff) && $stable(as_mask_ff))
    else $error("expanded write changed a primary register");

  AST_IDX_WR: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_wr && req_i.addr == OFS_TPL_INDEX
    |=> tpl_index_ff == $past(req_i.wdata))
    else $error("template index did not take written value");

  AST_FLAG_RO: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_wr && req_i.addr == OFS_DF_FLAG && df_set == 8'h00
    |=> $stable(df_flag_ff))
    else $error("write changed a read-only flag register");

  AST_AS_CLR: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    pri_rd && req_i.addr == OFS_AS_STATUS && as_set == 8'h00
    |=> as_flag_ff == FLAG_RESET)
    else $error("alarm status read did not clear its flag");

endmodule

// [liu_exp_bank_model.sv]
// Behavioural expanded register bank on the far side of exp_acc_o.
// Assumes accesses arrive combinationally with the host request.
`timescale 1ns/1ps
module liu_exp_bank_model
  import liu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic exp_acc_i,
  input wire liu_host_req_t req_i,
  output logic [7:0] exp_rdata_o
);
  logic [7:0] mem_ff [32];
  logic [7:0] last_ff;

  //////////////////////////////////////////////////////////////////////
  // Storage; every location, test ones included, starts at zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 32; i++) begin
        mem_ff[i] <= 8'h00;
      end
    end else if (exp_acc_i && req_i.wr) begin
      mem_ff[req_i.addr] <= req_i.wdata;
    end
  end

  // Last answer kept so an idle bus shows its inverse, not stale data
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      last_ff <= 8'h00;
    end else if (exp_acc_i && !req_i.wr) begin
      last_ff <= exp_rdata_o;
    end
  end

  // Answer only while selected
  always_comb begin
    exp_rdata_o = exp_acc_i ? mem_ff[req_i.addr] : ~last_ff;
  end
endmodule

// [liu_register_bank_tb.sv]
// Self-checking bench for the register bank decoder.
// Assumes the package and the expanded bank model are compiled first.
`timescale 1ns/1ps
module liu_register_bank_tb
  import liu_pkg::*;
;
  localparam logic [7:0] TB_CODE = 8'h3c; // Arbitrary value
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic acc_i = 1'b0;
  liu_host_req_t req_i = '0;
  logic rd_valid_o;
  logic [7:0] rdata_o;
  logic exp_acc_o;
  logic [7:0] exp_rdata_i;
  liu_line_stat_t line_stat_i;
  liu_line_cfg_t line_cfg_o;
  logic [LIU_TPL_DEPTH*8-1:0] tpl_entries_o;
  logic soft_reset_o;
  logic bank_expanded_o;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] sv [3] = '{8'h0f, 8'h33, 8'hc3};
  logic [4:0] st_ofs [3] = '{5'h04, 5'h05, 5'h13};
  logic [4:0] mk_ofs [3] = '{5'h06, 5'h07, 5'h14};
  logic [4:0] fl_ofs [3] = '{5'h08, 5'h09, 5'h15};
  logic [4:0] rw_ofs [12] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h0b,
                              5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h12, 5'h14};
  logic [7:0] d;

  //////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 ref_clk_i = ~ref_clk_i;

  liu_register_bank #(.DEVICE_CODE(TB_CODE)) i_dut (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .acc_i(acc_i),
    .req_i(req_i),
    .rd_valid_o(rd_valid_o),
    .rdata_o(rdata_o),
    .exp_acc_o(exp_acc_o),
    .exp_rdata_i(exp_rdata_i),
    .line_stat_i(line_stat_i),
    .line_cfg_o(line_cfg_o),
    .tpl_entries_o(tpl_entries_o),
    .soft_reset_o(soft_reset_o),
    .bank_expanded_o(bank_expanded_o)
  );

  liu_exp_bank_model i_exp (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .exp_acc_i(exp_acc_o),
    .req_i(req_i),
    .exp_rdata_o(exp_rdata_i)
  );

  //////////////////////////////////////////////////////////////////////
  // Tasks: compare, host accesses, verdict
  task automatic results();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge ref_clk_i);
    acc_i = 1'b1;
    req_i = '{wr: 1'b1, addr: a, wdata: v};
    @(negedge ref_clk_i);
    acc_i = 1'b0;
  endtask

  // Bounded wait for the read answer; the pulse stands one cycle, so it
  // is looked at there
  task automatic rd_wait(input logic [7:0] exp);
    int n;
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 4) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (rd_valid_o !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t no read answer", $time);
      results();
    end else begin
      chk(rdata_o, exp);
    end
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    @(negedge ref_clk_i);
    acc_i = 1'b1;
    req_i = '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge ref_clk_i);
    acc_i = 1'b0;
    rd_wait(exp);
  endtask

  // Write, then read the same offset at the very next edge
  task automatic wr_rc(input logic [4:0] a, input logic [7:0] v);
    @(negedge ref_clk_i);
    acc_i = 1'b1;
    req_i = '{wr: 1'b1, addr: a, wdata: v};
    @(negedge ref_clk_i);
    req_i.wr = 1'b0;
    @(negedge ref_clk_i);
    acc_i = 1'b0;
    rd_wait(v);
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    line_stat_i = {sv[0], sv[1], sv[2]};
    repeat (3) @(negedge ref_clk_i);
    srst_i = 1'b0;
    // Reset state and identity
    rc(OFS_DEVICE_CODE, TB_CODE);
    rc(OFS_BANK_PTR, BANK_PTR_RESET);
    chk({7'h00, bank_expanded_o}, 8'h00);
    wr(OFS_DEVICE_CODE, 8'hff);
    rc(OFS_DEVICE_CODE, TB_CODE);
    // Read/write configuration and mask registers, read back at once
    foreach (rw_ofs[i]) begin
      rc(rw_ofs[i], CFG_RESET);
      d = 8'h5a ^ 8'(i);
      wr_rc(rw_ofs[i], d);
    end
    chk(line_cfg_o.analog_lb, 8'h5a);
    chk(line_cfg_o.out_en, 8'h50);
    // Status and flag registers refuse writes
    for (int i = 0; i < 3; i++) begin
      wr(st_ofs[i], 8'hff);
      rc(st_ofs[i], sv[i]);
      wr(fl_ofs[i], 8'hff);
      rc(fl_ofs[i], FLAG_RESET);
    end
    // Reserved primary offsets
    for (int a = OFS_RSVD_FIRST; a <= OFS_RSVD_LAST; a++) begin
      wr(5'(a), 8'hff);
      rc(5'(a), READ_ZERO);
    end
    // Masked status change raises flag; status read clears it
    for (int i = 0; i < 3; i++) begin
      wr(mk_ofs[i], 8'h3c);
      @(negedge ref_clk_i);
      sv[i] = sv[i] ^ 8'h5a;
      line_stat_i = {sv[0], sv[1], sv[2]};
      rc(fl_ofs[i], 8'h3c & 8'h5a);
      rc(st_ofs[i], sv[i]);
      rc(fl_ofs[i], FLAG_RESET);
    end
    // Template entries through index then data
    wr(OFS_TPL_INDEX, 8'h03);
    wr(OFS_TPL_DATA, 8'ha5);
    wr(OFS_TPL_INDEX, 8'h05);
    wr_rc(OFS_TPL_DATA, 8'h5a);
    wr(OFS_TPL_INDEX, 8'h03);
    rc(OFS_TPL_DATA, 8'ha5);
    rc(OFS_TPL_INDEX, 8'h03);
    chk(tpl_entries_o[47:40], 8'h5a);
    // Expanded bank selected by the pointer
    wr(OFS_BANK_PTR, BANK_EXPANDED);
    chk({7'h00, bank_expanded_o}, 8'h01);
    rc(OFS_BANK_PTR, BANK_EXPANDED);
    rc(OFS_TPL_INDEX, 8'h00);
    wr(OFS_REMOTE_LB, 8'h77);
    rc(OFS_REMOTE_LB, 8'h77);
    chk(line_cfg_o.remote_lb, 8'h5b);
    wr(OFS_BANK_PTR, 8'h00);
    chk({7'h00, bank_expanded_o}, 8'h00);
    rc(OFS_REMOTE_LB, 8'h5b);
    // Software reset
    wr(OFS_SOFT_RESET, 8'h01);
    chk({7'h00, soft_reset_o}, 8'h01);
    chk(line_cfg_o.analog_lb, CFG_RESET);
    rc(OFS_SOFT_RESET, READ_ZERO);
    rc(OFS_TPL_DATA, TPL_RESET);
    // Mid-run hard reset returns the pointer to the primary bank
    wr(OFS_GLOBAL, 8'h81);
    wr(OFS_BANK_PTR, BANK_EXPANDED);
    @(negedge ref_clk_i);
    srst_i = 1'b1;
    @(negedge ref_clk_i);
    srst_i = 1'b0;
    chk({7'h00, bank_expanded_o}, 8'h00);
    rc(OFS_BANK_PTR, BANK_PTR_RESET);
    rc(OFS_GLOBAL, CFG_RESET);
    results();
  end
endmodule
